// ==== rtl/rtdm_pkg.sv ====
// constants shared by the table-read and d-move execution logic
package rtdm_pkg;
   // ************************************************
   // widths and codes
   // ************************************************
   localparam int         RTDM_IW         = 10;
   localparam int         RTDM_PCW        = 12;
   localparam int         RTDM_LOW_W      = 7;
   localparam int         RTDM_PAGE_W     = 5;
   localparam logic [4:0] RTDM_TABLE_OP   = 5'h04;
   localparam logic [9:0] RTDM_DMOVE_OP   = 10'h051;
   localparam int         RTDM_TABLE_CYC  = 3;
   localparam int         RTDM_DMOVE_CYC  = 1;
   localparam logic [2:0] RTDM_SP_RST     = 3'h7;
   localparam logic [11:0] RTDM_PC_RST    = 12'h000;
   // ************************************************
   // sequencer states
   // ************************************************
   typedef enum logic [2:0] {
      RTDM_IDLE  = 3'b001,
      RTDM_FETCH = 3'b010,
      RTDM_POP   = 3'b100
   } rtdm_state_e;
endpackage

// ==== rtl/rtdm_decode.sv ====
// instruction word decoder for table read and d move
`timescale 1ns/1ps
module rtdm_decode
   import rtdm_pkg::*;
(
   input  wire logic [9:0] instr,       // instruction word
   output logic            is_table,    // table read decoded
   output logic            is_dmove,    // d move decoded
   output logic [4:0]      page         // page operand
);
   // fixed upper five bits select table read
   assign is_table = (instr[9:5] == RTDM_TABLE_OP);
   assign is_dmove = (instr == RTDM_DMOVE_OP);
   assign page     = instr[4:0];
endmodule

// ==== rtl/rtdm_core.sv ====
// execution logic for the table-read and d-move instructions
`timescale 1ns/1ps
module rtdm_core
   import rtdm_pkg::*;
#(
   parameter int SP_W = 3              // stack index width
)
(
   input  wire logic             sys_clk,      // 40 mhz core clock
   input  wire logic             rst,          // sync reset, high
   input  wire logic             ce,           // clock enable
   input  wire logic             instr_valid,  // instr present
   input  wire logic [9:0]       instr,        // instruction word
   input  wire logic [11:0]      pc_in,        // current pc
   input  wire logic [2:0]       d_index_reg,  // register d
   input  wire logic [3:0]       acc_in,       // accumulator value
   input  wire logic [7:0]       rom_data,     // rom byte, next cycle
   output logic [11:0]           rom_addr,     // program memory addr
   output logic [3:0]            acc_out,      // new accumulator
   output logic                  acc_we,       // accumulator write
   output logic [3:0]            b_out,        // new register b
   output logic                  b_we,         // register b write
   output logic [11:0]           pc_out,       // pc override
   output logic                  pc_we,        // pc override write
   output logic                  busy,         // multi-cycle stall
   output logic [SP_W-1:0]       stack_index,  // return stack index
   output logic                  carry_we,     // carry write, never
   output logic                  skip_next     // skip request, never
);
   logic                is_table;
   logic                is_dmove;
   logic [4:0]          page;
   rtdm_state_e         state_reg;
   logic [11:0]         return_stack [2**SP_W];

   // function: table address from page, d and accumulator
   function automatic logic [11:0] tbl_addr(input logic [4:0] p,
                                            input logic [2:0] d,
                                            input logic [3:0] a);
      tbl_addr = {p, d, a};
   endfunction

   rtdm_decode u_dec (
      .instr    (instr),
      .is_table (is_table),
      .is_dmove (is_dmove),
      .page     (page)
   );

   wire logic start_tbl = ce && instr_valid && is_table &&
                          (state_reg == RTDM_IDLE);
   wire logic start_dmv = ce && instr_valid && is_dmove &&
                          (state_reg == RTDM_IDLE);

   // ************************************************
   // sequencer
   // ************************************************
   // three cycles: push/address, fetch byte, pop
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= RTDM_IDLE;
      end else if (ce) begin
         unique case (state_reg)
            RTDM_IDLE: begin
               if (start_tbl) begin
                  state_reg <= RTDM_FETCH;
               end
            end
            RTDM_FETCH: begin
               state_reg <= RTDM_POP;
            end
            RTDM_POP: begin
               state_reg <= RTDM_IDLE;
            end
         endcase
      end
   end

   // ************************************************
   // return stack
   // ************************************************
   // push on entry, pop on exit; no overflow check, software
   // must leave a spare level
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stack_index <= SP_W'(RTDM_SP_RST);
      end else if (ce) begin
         if (start_tbl) begin
            stack_index <= stack_index + 1'b1;
         end else if (state_reg == RTDM_POP) begin
            stack_index <= stack_index - 1'b1;
         end
      end
   end

   // stack entry written at the incremented index
   always_ff @(posedge sys_clk) begin
      if (ce && start_tbl) begin
         return_stack[stack_index + 1'b1] <= pc_in;
      end
   end

   // ************************************************
   // memory address and byte transfer
   // ************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rom_addr <= RTDM_PC_RST;
      end else if (ce && start_tbl) begin
         rom_addr <= tbl_addr(page, d_index_reg, acc_in);
      end
   end

   // results: byte split, or d copied with bit 3 cleared
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_out <= 4'h0;
         b_out   <= 4'h0;
         acc_we  <= 1'b0;
         b_we    <= 1'b0;
      end else if (ce) begin
         acc_we <= 1'b0;
         b_we   <= 1'b0;
         if (state_reg == RTDM_FETCH) begin
            b_out   <= rom_data[7:4];
            acc_out <= rom_data[3:0];
            acc_we  <= 1'b1;
            b_we    <= 1'b1;
         end else if (start_dmv) begin
            acc_out <= {1'b0, d_index_reg};
            acc_we  <= 1'b1;
         end
      end
   end

   // pc restored from the stack entry at the pop
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pc_out <= RTDM_PC_RST;
         pc_we  <= 1'b0;
      end else if (ce) begin
         // pc_out keeps its last value, only pc_we marks it fresh
         pc_we <= 1'b0;
         if (state_reg == RTDM_POP) begin
            pc_out <= return_stack[stack_index];
            pc_we  <= 1'b1;
         end
      end
   end

   // busy covers the two extra cycles of the table read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (ce) begin
         busy <= start_tbl || (state_reg == RTDM_FETCH);
      end
   end

   // neither instruction touches carry or skip
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         carry_we  <= 1'b0;
         skip_next <= 1'b0;
      end else if (ce) begin
         carry_we  <= 1'b0;
         skip_next <= 1'b0;
      end
   end

   // ************************************************
   // assertions
   // ************************************************
   // push lands one above the resting index, wrapping at the top
   a_tbl_push: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_tbl |=> stack_index == SP_W'($past(stack_index) + 1'b1))
      else $error("stack index not pushed");

   // after three enabled cycles the index is back where it began
   a_tbl_push_pop: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_tbl ##1 ce ##1 ce |=>
      stack_index == $past(stack_index, 3))
      else $error("stack index not restored");

   // fetch address is page, then d, then accumulator
   a_tbl_addr: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_tbl |=> rom_addr == {$past(page), $past(d_index_reg),
                                 $past(acc_in)})
      else $error("table address wrong");

   // high nibble to b, low nibble to the accumulator
   a_tbl_split: assert property (
      @(posedge sys_clk) disable iff (rst)
      ce && state_reg == RTDM_FETCH |=>
      b_we && acc_we && b_out == $past(rom_data[7:4]) &&
      acc_out == $past(rom_data[3:0]))
      else $error("byte split wrong");

   // the return pc comes back from the stack entry
   a_tbl_pc_back: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_tbl ##1 ce ##1 ce |=> pc_we && pc_out == $past(pc_in, 3))
      else $error("pc not restored");

   // busy for exactly the two extra cycles of the read
   a_tbl_cycles: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_tbl ##1 ce ##1 ce |-> (busy && $past(busy)) ##1 !busy)
      else $error("table read length wrong");

   // a word offered during the pop is ignored, not executed
   a_busy_refuse: assert property (
      @(posedge sys_clk) disable iff (rst)
      ce && state_reg == RTDM_POP |=> !acc_we && !b_we)
      else $error("instruction taken while busy");

   // d copied into the low bits, b left alone
   a_dmove_val: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_dmv |=> acc_we && !b_we &&
      acc_out == {1'b0, $past(d_index_reg)})
      else $error("d move value wrong");

   // bit 3 is cleared whatever the accumulator held before
   a_dmove_bit3: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_dmv |=> acc_out[3] == 1'b0)
      else $error("d move bit 3 set");

   // carry and skip are never requested by these instructions
   a_no_carry: assert property (
      @(posedge sys_clk) disable iff (rst)
      !carry_we && !skip_next)
      else $error("carry or skip asserted");
endmodule

// ==== verif/rtdm_rom_model.sv ====
// behavioural program memory that answers the table-read fetch
`timescale 1ns/1ps
module rtdm_rom_model (
   input  wire logic [11:0] rom_addr,  // page and in-page address
   output logic      [7:0]  rom_data   // byte stored at rom_addr
);
   // ****************************************************
   // contents
   // ****************************************************
   // page enters the pattern so a wrong page gives a wrong byte
   assign rom_data = rom_addr[7:0] + {rom_addr[11:7], 3'h5};
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the table-read and d-move execution logic
`timescale 1ns/1ps
module tb_top;
   import rtdm_pkg::*;
   logic        sys_clk     = 1'b0;
   logic        rst         = 1'b1;
   logic        ce          = 1'b1;
   logic        instr_valid = 1'b0;
   logic [9:0]  instr       = 10'h000;
   logic [11:0] pc_in       = 12'h000;
   logic [2:0]  d_index_reg = 3'h0;
   logic [3:0]  acc_in      = 4'h0;
   logic [7:0]  rom_data;
   logic [11:0] rom_addr, pc_out;
   logic [3:0]  acc_out, b_out;
   logic [2:0]  stack_index;
   logic        acc_we, b_we, pc_we, busy, carry_we, skip_next;
   int          fail_count = 0;
   int          compares   = 0;
   int          cycles     = 0;
   // ****************************************************
   // clock, design and memory
   // ****************************************************
   always #12.5 sys_clk = ~sys_clk;
   // clock enable driven so that a frozen table read is exercised too
   rtdm_core #(.SP_W(3)) i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
      .instr_valid(instr_valid), .instr(instr), .pc_in(pc_in),
      .d_index_reg(d_index_reg), .acc_in(acc_in), .rom_data(rom_data),
      .rom_addr(rom_addr), .acc_out(acc_out), .acc_we(acc_we),
      .b_out(b_out), .b_we(b_we), .pc_out(pc_out), .pc_we(pc_we),
      .busy(busy), .stack_index(stack_index), .carry_we(carry_we),
      .skip_next(skip_next));
   rtdm_rom_model i_rom (.rom_addr(rom_addr), .rom_data(rom_data));
   // ****************************************************
   // helpers
   // ****************************************************
   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic finish_test();
      $display("fail_count=%0d compares=%0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // hang guard, the whole run needs well under 200 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         $display("ERROR %0t run did not finish", $time);
         finish_test();
      end
   end
   // ****************************************************
   // scenarios
   // ****************************************************
   // eight back-to-back moves with a full accumulator
   task automatic dmove_run();
      logic [3:0] exp_acc;
      for (int i = 0; i < 9; i++) begin
         @(posedge sys_clk);
         instr_valid <= (i < 8);
         instr       <= RTDM_DMOVE_OP;
         d_index_reg <= i[2:0];
         acc_in      <= 4'hf;
         #1;
         exp_acc = {1'b0, 3'(i - 1)};
         if (i > 0) check(acc_we && !b_we && acc_out === exp_acc,
                          "d move result");
         check(!carry_we && !skip_next, "carry or skip");
      end
   endtask
   // one table read with a d move held on the bus while busy
   task automatic tread(input logic [4:0] p, input logic [2:0] d,
                        input logic [3:0] a);
      logic [11:0] adr;
      logic [7:0]  exp_byte;
      adr      = {p, d, a};
      exp_byte = adr[7:0] + {p, 3'h5};
      @(posedge sys_clk);
      instr       <= {RTDM_TABLE_OP, p};
      instr_valid <= 1'b1;
      d_index_reg <= d;
      acc_in      <= a;
      pc_in       <= ~adr;
      @(posedge sys_clk);
      instr <= RTDM_DMOVE_OP;
      #1;
      check(rom_addr === adr && busy === 1'b1, "fetch address");
      check(stack_index === 3'h0, "push index");
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
      check(acc_we && acc_out === exp_byte[3:0], "low nibble");
      check(b_we && b_out === exp_byte[7:4], "high nibble");
      @(posedge sys_clk);
      #1;
      check(pc_we === 1'b1 && pc_out === ~adr, "return pc");
      check(stack_index === 3'h7 && busy === 1'b0, "pop index");
      check(!acc_we, "held move taken");
      check(!carry_we && !skip_next, "read flags");
   endtask
   // table read frozen by the clock enable for one cycle; the held d move
   // must wait and then be taken at the first idle edge
   task automatic tread_freeze(input logic [4:0] p, input logic [2:0] d,
                               input logic [3:0] a);
      logic [11:0] adr;
      logic [7:0]  exp_byte;
      adr      = {p, d, a};
      exp_byte = adr[7:0] + {p, 3'h5};
      @(posedge sys_clk);
      instr       <= {RTDM_TABLE_OP, p};
      instr_valid <= 1'b1;
      d_index_reg <= d;
      acc_in      <= a;
      pc_in       <= ~adr;
      @(posedge sys_clk);
      instr <= RTDM_DMOVE_OP;
      ce    <= 1'b0;
      #1;
      check(rom_addr === adr && busy === 1'b1, "frozen address");
      @(posedge sys_clk);
      ce <= 1'b1;
      #1;
      check(busy === 1'b1 && !acc_we && !b_we, "frozen step");
      check(stack_index === 3'h0, "frozen index");
      @(posedge sys_clk);
      #1;
      check(acc_we && acc_out === exp_byte[3:0], "frozen low nibble");
      check(b_we && b_out === exp_byte[7:4], "frozen high nibble");
      @(posedge sys_clk);
      #1;
      check(pc_we && pc_out === ~adr && !acc_we, "frozen return");
      check(stack_index === 3'h7 && busy === 1'b0, "frozen pop");
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
      check(acc_we && !b_we && acc_out === {1'b0, d},
            "move after read");
   endtask
   // reset in the middle of a table read returns the core to rest
   task automatic reset_mid_read();
      @(posedge sys_clk);
      instr       <= {RTDM_TABLE_OP, 5'h0a};
      instr_valid <= 1'b1;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      rst         <= 1'b1;
      #1;
      check(busy === 1'b1, "read begun before reset");
      @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      check(stack_index === 3'h7 && busy === 1'b0, "reset index");
      check(!acc_we && !b_we && !pc_we, "reset strobes");
      @(posedge sys_clk);
      #1;
      check(!acc_we && !pc_we && busy === 1'b0, "quiet after reset");
   endtask
   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      // index rests at 7, so one level stays spare for the fetch
      check(stack_index === 3'h7 && busy === 1'b0, "reset state");
      dmove_run();
      tread(5'h00, 3'h7, 4'hf);
      tread(5'h1f, 3'h0, 4'h0);
      tread(5'h11, 3'h5, 4'ha);
      tread_freeze(5'h06, 3'h3, 4'h9);
      reset_mid_read();
      tread(5'h15, 3'h2, 4'h6);
      dmove_run();
      finish_test();
   end
endmodule
